/* File: hdl/ea_adder.sv */
// effective address adder for the eight locator forms
`timescale 1ns/1ps
module ea_adder
    import opdec_pkg::*;
(
    ea_if.adder ea  // register values in, sum out
);
    always_comb begin
        case (ea.locator)
            3'h0: ea.sum = ea.base_reg + ea.src_index_reg + ea.disp;
            3'h1: ea.sum = ea.base_reg + ea.dest_index_reg + ea.disp;
            3'h2: ea.sum = ea.base_ptr_reg + ea.src_index_reg + ea.disp;
            3'h3: ea.sum = ea.base_ptr_reg + ea.dest_index_reg + ea.disp;
            3'h4: ea.sum = ea.src_index_reg + ea.disp;
            3'h5: ea.sum = ea.dest_index_reg + ea.disp;
            3'h6: ea.sum = ea.base_ptr_reg + ea.disp;
            default: ea.sum = ea.base_reg + ea.disp;
        endcase
    end
endmodule

/* File: hdl/ea_if.sv */
// interface carrying register values into the address adder
`timescale 1ns/1ps
interface ea_if;
    logic [15:0] base_reg;
    logic [15:0] base_ptr_reg;
    logic [15:0] src_index_reg;
    logic [15:0] dest_index_reg;
    logic [15:0] disp;
    logic [2:0]  locator;
    logic [15:0] sum;
    modport adder (input base_reg, base_ptr_reg, src_index_reg,
                   dest_index_reg, disp, locator, output sum);
    modport user  (output base_reg, base_ptr_reg, src_index_reg,
                   dest_index_reg, disp, locator, input sum);
endinterface

/* File: hdl/opdec_pkg.sv */
// shared constants and types for the operand address decoder
package opdec_pkg;
    localparam logic [1:0] MOD_NO_DISP   = 2'h0;
    localparam logic [1:0] MOD_DISP8     = 2'h1;
    localparam logic [1:0] MOD_DISP16    = 2'h2;
    localparam logic [1:0] MOD_REGISTER  = 2'h3;
    localparam logic [2:0] RM_DIRECT     = 3'h6;
    localparam logic [2:0] SEG_PFX_HEAD  = 3'h1;
    localparam logic [2:0] SEG_PFX_TAIL  = 3'h6;
    localparam logic [7:0] OP_LOCK       = 8'hf0;
    localparam logic [7:0] OP_CMC        = 8'hf5;
    localparam logic [7:0] OP_HLT        = 8'hf4;
    localparam logic [6:0] OP_FLAG_HI    = 7'h7c; // f8..f9, fa..fb, fc..fd
    localparam logic [7:0] OP_IRQ_MASK_CLEAR = 8'hfa;
    localparam int         FLAG_OP_NS    = 40;
    localparam int         EA_TIME_NS    = 80;
    localparam int         CLK_PERIOD_NS = 20;
    localparam logic [3:0] FLAG_OP_CYC   = 4'((FLAG_OP_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS);
    localparam logic [3:0] EA_CYC        = 4'((EA_TIME_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS);
    localparam logic [3:0] WORD_XFER_ADD = 4'h4;
    localparam logic [1:0] SEG_EXTRA     = 2'h0;
    localparam logic [1:0] SEG_CODE      = 2'h1;
    localparam logic [1:0] SEG_STACK     = 2'h2;
    localparam logic [1:0] SEG_DATA      = 2'h3;
    typedef enum logic [2:0] {
        REG_W_ACC, REG_W_CNT, REG_W_DAT, REG_W_BASE,
        REG_W_SP, REG_W_BPTR, REG_W_SRC, REG_W_DST
    } reg_sel_t;
endpackage

/* File: hdl/operand_address_decoder.sv */
// operand addressing decoder: mod/locator bytes to address and segment
// Behaviour
// - kind 11 selects register, not memory
// - kind 00 no displacement; 110 direct address
// - kind 01 one byte, sign extended
// - kind 10 two bytes, high above low
// - locators 000-011 sum two registers plus displacement
// - locators 100-111 one register plus displacement
// - displacement follows second byte, before immediates
// - address computation takes four cycles
// - override prefix 001ss110 picks es/cs/ss/ds
// - register code maps word or byte registers
// - base pointer forms default to stack segment
// - string destination always extra segment
// - word memory transfer adds four cycles
// - flag control ops take two cycles
// - lock prefix recognised, two cycles
`timescale 1ns/1ps
module operand_address_decoder
    import opdec_pkg::*;
(
    input  wire logic        REF_CLK,       // processor clock
    input  wire logic        RST,           // async reset, high
    input  wire logic [7:0]  BYTE_IN,       // instruction byte
    input  wire logic        BYTE_VALID,    // byte offered
    output logic             BYTE_READY,    // byte taken this cycle
    input  wire logic        BYTE_FIRST,    // byte is opcode/prefix
    input  wire logic        HAS_MODRM,     // opcode has addressing byte
    input  wire logic        WORD_OP,       // width bit of opcode
    input  wire logic        STRING_DEST,   // string destination operand
    input  wire logic [15:0] BASE_REG,      // base register value
    input  wire logic [15:0] BASE_PTR_REG,  // base pointer value
    input  wire logic [15:0] SRC_INDEX_REG, // source index value
    input  wire logic [15:0] DEST_INDEX_REG,// dest index value
    output logic             OUT_VALID,     // decoded result ready
    input  wire logic        OUT_ACCEPT,    // execution unit takes it
    output logic [15:0]      EFFECTIVE_ADDRESS, // computed address
    output logic [1:0]       SEGMENT,       // selected segment
    output logic             IS_REGISTER,   // operand is a register
    output logic [2:0]       RM_REG,        // register operand code
    output logic [2:0]       REG_FIELD,     // middle field code
    output logic [3:0]       REG_INDEX,     // {byte high,reg} resolved
    output logic             LOCKED,        // lock prefix applies
    output logic             IS_CTRL_OP,    // processor control op
    output logic [7:0]       CYCLES         // cycles charged
);
    typedef enum {S_OP, S_MODRM, S_DLO, S_DHI, S_CALC, S_HOLD} st_t;
    st_t st, next_st;
    logic [7:0]  opc, next_opc, dlo, next_dlo, dhi, next_dhi, modrm;
    logic [7:0]  next_modrm, cyc, next_cyc;
    logic [1:0]  ovr, next_ovr;
    logic        ovr_on, next_ovr_on, lock, next_lock, wop, next_wop;
    logic        sdst, next_sdst;
    logic [3:0]  cnt, next_cnt;
    logic [15:0] ea_q, next_ea_q, disp;
    logic [1:0]  seg, next_seg;
    ea_if ea ();

    ea_adder u_adder (.ea(ea));

    always_comb begin
        case (modrm[7:6])
            MOD_DISP8:  disp = {{8{dlo[7]}}, dlo};
            MOD_DISP16: disp = {dhi, dlo};
            default:    disp = 16'h0000;
        endcase
    end
    assign ea.base_reg       = BASE_REG;
    assign ea.base_ptr_reg   = BASE_PTR_REG;
    assign ea.src_index_reg  = SRC_INDEX_REG;
    assign ea.dest_index_reg = DEST_INDEX_REG;
    assign ea.disp           = disp;
    assign ea.locator        = modrm[2:0];

    assign BYTE_READY = (st == S_OP || st == S_MODRM || st == S_DLO
                         || st == S_DHI) && BYTE_VALID;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_opc = opc;
        next_dlo = dlo;
        next_dhi = dhi;
        next_modrm = modrm;
        next_cyc = cyc;
        next_ovr = ovr;
        next_ovr_on = ovr_on;
        next_lock = lock;
        next_wop = wop;
        next_sdst = sdst;
        next_cnt = cnt;
        next_ea_q = ea_q;
        next_seg = seg;
        case (st)
            S_OP: begin
                if (BYTE_READY && BYTE_FIRST) begin
                    if (BYTE_IN[7:5] == SEG_PFX_HEAD
                        && BYTE_IN[2:0] == SEG_PFX_TAIL) begin
                        next_ovr = BYTE_IN[4:3];
                        next_ovr_on = 1'b1;
                    end else if (BYTE_IN == OP_LOCK) begin
                        // lock marks the next result, not its own
                        next_opc = BYTE_IN;
                        next_modrm = 8'hc0;
                        next_cyc = {4'h0, FLAG_OP_CYC};
                        next_st = S_HOLD;
                    end else begin
                        next_opc = BYTE_IN;
                        next_wop = WORD_OP;
                        next_sdst = STRING_DEST;
                        next_dlo = 8'h00;
                        next_dhi = 8'h00;
                        if (HAS_MODRM) begin
                            next_st = S_MODRM;
                        end else begin
                            next_modrm = 8'hc0;
                            next_cyc = ((BYTE_IN[7:3] == OP_FLAG_HI[6:2]
                                && BYTE_IN[2:1] != 2'h3)
                                || BYTE_IN == OP_CMC
                                || BYTE_IN == OP_HLT)
                                ? {4'h0, FLAG_OP_CYC} : 8'h00;
                            next_st = S_HOLD;
                        end
                    end
                end
            end
            S_MODRM: begin
                if (BYTE_READY) begin
                    next_modrm = BYTE_IN;
                    // displacement bytes directly after this byte
                    if (BYTE_IN[7:6] == MOD_DISP8
                        || BYTE_IN[7:6] == MOD_DISP16) begin
                        next_st = S_DLO;
                    end else if (BYTE_IN[7:6] == MOD_NO_DISP
                                 && BYTE_IN[2:0] == RM_DIRECT) begin
                        next_st = S_DLO;
                    end else begin
                        next_cnt = EA_CYC;
                        next_st = S_CALC;
                    end
                end
            end
            S_DLO: begin
                if (BYTE_READY) begin
                    next_dlo = BYTE_IN;
                    if (modrm[7:6] == MOD_DISP8) begin
                        next_cnt = EA_CYC;
                        next_st = S_CALC;
                    end else begin
                        next_st = S_DHI;
                    end
                end
            end
            S_DHI: begin
                if (BYTE_READY) begin
                    next_dhi = BYTE_IN;
                    next_cnt = EA_CYC;
                    next_st = S_CALC;
                end
            end
            S_CALC: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_st = S_HOLD;
                    next_cyc = {4'h0, EA_CYC
                                + (wop && modrm[7:6] != MOD_REGISTER
                                   ? WORD_XFER_ADD : 4'h0)};
                end
            end
            S_HOLD: begin
                if (OUT_ACCEPT) begin
                    next_st = S_OP;
                    next_ovr_on = 1'b0;
                    next_lock = (opc == OP_LOCK);
                end
            end
            default: next_st = S_OP;
        endcase
        if (st == S_CALC) begin
            if (modrm[7:6] == MOD_NO_DISP && modrm[2:0] == RM_DIRECT)
                next_ea_q = {dhi, dlo};
            else
                next_ea_q = ea.sum;
            if (sdst)
                next_seg = SEG_EXTRA;
            else if (ovr_on)
                next_seg = ovr;
            else if (modrm[2:0] == 3'h2 || modrm[2:0] == 3'h3
                     || (modrm[2:0] == RM_DIRECT
                         && modrm[7:6] != MOD_NO_DISP))
                next_seg = SEG_STACK;
            else
                next_seg = SEG_DATA;
        end else if (st == S_MODRM && sdst) begin
            next_seg = SEG_EXTRA;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st <= S_OP;
            opc <= 8'h00;
            dlo <= 8'h00;
            dhi <= 8'h00;
            modrm <= 8'h00;
            cyc <= 8'h00;
            ovr <= 2'h0;
            ovr_on <= 1'b0;
            lock <= 1'b0;
            wop <= 1'b0;
            sdst <= 1'b0;
            cnt <= 4'h0;
            ea_q <= 16'h0000;
            seg <= SEG_DATA;
        end else begin
            st <= next_st;
            opc <= next_opc;
            dlo <= next_dlo;
            dhi <= next_dhi;
            modrm <= next_modrm;
            cyc <= next_cyc;
            ovr <= next_ovr;
            ovr_on <= next_ovr_on;
            lock <= next_lock;
            wop <= next_wop;
            sdst <= next_sdst;
            cnt <= next_cnt;
            ea_q <= next_ea_q;
            seg <= next_seg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign OUT_VALID         = (st == S_HOLD);
    assign EFFECTIVE_ADDRESS = ea_q;
    assign SEGMENT           = seg;
    assign IS_REGISTER       = (modrm[7:6] == MOD_REGISTER);
    assign RM_REG            = modrm[2:0];
    assign REG_FIELD         = modrm[5:3];
    // word: codes 0..7 direct; byte: 0..3 low bytes, 4..7 high of 0..3
    assign REG_INDEX = wop ? {1'b0, modrm[2:0]}
                           : {modrm[2], 1'b0, modrm[1:0]};
    assign LOCKED            = lock;
    assign IS_CTRL_OP        = (cyc == {4'h0, FLAG_OP_CYC})
                               && IS_REGISTER
                               && ((opc[7:4] == 4'hf) || (opc == 8'h9b));
    assign CYCLES            = cyc;
endmodule

/* File: sim/exec_model.sv */
// execution unit stand-in taking results after random stalls
`timescale 1ns/1ps
module exec_model (
    input  wire logic REF_CLK,    // clock
    input  wire logic OUT_VALID,  // result offered
    output logic      OUT_ACCEPT  // result taken
);
    initial OUT_ACCEPT = 1'b0;
    // stalls prove that results stand until taken
    always @(posedge REF_CLK) begin
        #1 OUT_ACCEPT = OUT_VALID && ($urandom_range(2) == 0);
    end
endmodule

/* File: sim/operand_address_decoder_bench.sv */
// self-checking bench for the operand address decoder
`timescale 1ns/1ps
module operand_address_decoder_bench;
    import opdec_pkg::*;
    typedef struct {
        logic [1:0]  k;
        logic [15:0] ea;
        logic [1:0]  seg;
        logic [7:0]  cyc;
        logic [3:0]  ri;
        logic [2:0]  rm;
        logic [2:0]  rf;
        logic        lk;
    } exp_t;
    logic        REF_CLK, RST, BYTE_VALID, BYTE_READY, BYTE_FIRST, LOCKED;
    logic        HAS_MODRM, WORD_OP, STRING_DEST, OUT_VALID, OUT_ACCEPT;
    logic        IS_REGISTER, IS_CTRL_OP, lkn;
    logic [15:0] BASE_REG, BASE_PTR_REG, SRC_INDEX_REG, DEST_INDEX_REG;
    logic [15:0] EFFECTIVE_ADDRESS;
    logic [7:0]  BYTE_IN, CYCLES;
    logic [3:0]  REG_INDEX;
    logic [2:0]  RM_REG, REG_FIELD;
    logic [1:0]  SEGMENT;
    logic [7:0]  ops [8] = '{8'hf8, 8'hf9, OP_IRQ_MASK_CLEAR, 8'hfb,
                             8'hfc, 8'hfd, OP_CMC, OP_HLT};
    exp_t        q [$];
    exp_t        me;
    int          n_errors = 0;
    int          tests_run = 0;
    operand_address_decoder dut (.REF_CLK, .RST, .BYTE_IN, .BYTE_VALID,
        .BYTE_READY, .BYTE_FIRST, .HAS_MODRM, .WORD_OP, .STRING_DEST,
        .BASE_REG, .BASE_PTR_REG, .SRC_INDEX_REG, .DEST_INDEX_REG,
        .OUT_VALID, .OUT_ACCEPT, .EFFECTIVE_ADDRESS, .SEGMENT, .IS_REGISTER,
        .RM_REG, .REG_FIELD, .REG_INDEX, .LOCKED, .IS_CTRL_OP, .CYCLES);
    exec_model eu (.REF_CLK, .OUT_VALID, .OUT_ACCEPT);
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] ex, got);
        tests_run++;
        if (got !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, ex, got);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic idle;
        do begin @(posedge REF_CLK); #1; end while (q.size() != 0);
    endtask
    task automatic put(input logic [7:0] b, input logic f);
        BYTE_IN = b;
        BYTE_FIRST = f;
        BYTE_VALID = 1'b1;
        @(posedge REF_CLK);
        while (BYTE_READY !== 1'b1) @(posedge REF_CLK);
        #1;
    endtask
    task automatic instr(input logic [7:0] op, m, input logic mr,
                         input logic [15:0] d, input logic w, sd,
                         input int pfx);
        exp_t e;
        logic [15:0] dsp;
        logic        dir;
        idle();
        {BASE_REG, BASE_PTR_REG} = {16'($urandom), 16'($urandom)};
        {SRC_INDEX_REG, DEST_INDEX_REG} = {16'($urandom), 16'($urandom)};
        dir = m[7:6] == MOD_NO_DISP && m[2:0] == RM_DIRECT;
        dsp = m[7:6] == MOD_DISP8 ? {{8{d[7]}}, d[7:0]} :
              m[7:6] == MOD_DISP16 ? d : 16'h0000;
        case (m[2:0])
            3'h0: e.ea = BASE_REG + SRC_INDEX_REG + dsp;
            3'h1: e.ea = BASE_REG + DEST_INDEX_REG + dsp;
            3'h2: e.ea = BASE_PTR_REG + SRC_INDEX_REG + dsp;
            3'h3: e.ea = BASE_PTR_REG + DEST_INDEX_REG + dsp;
            3'h4: e.ea = SRC_INDEX_REG + dsp;
            3'h5: e.ea = DEST_INDEX_REG + dsp;
            3'h6: e.ea = dir ? d : BASE_PTR_REG + dsp;
            default: e.ea = BASE_REG + dsp;
        endcase
        e.k = !mr ? 2'h2 : m[7:6] == MOD_REGISTER ? 2'h1 : 2'h0;
        e.cyc = !mr ? 8'h02 : w ? 8'h08 : 8'h04;
        e.ri = w ? {1'b0, m[2:0]} : {m[2], 1'b0, m[1:0]};
        e.rm = m[2:0];
        e.rf = m[5:3];
        e.seg = sd ? SEG_EXTRA : pfx >= 0 ? 2'(pfx) :
                m[1] && m[2:0] != 3'h7 && !dir ? SEG_STACK : SEG_DATA;
        e.lk = lkn;
        lkn = op == OP_LOCK;
        q.push_back(e);
        {HAS_MODRM, WORD_OP, STRING_DEST} = {mr, w, sd};
        if (pfx >= 0) put({SEG_PFX_HEAD, 2'(pfx), SEG_PFX_TAIL}, 1'b1);
        put(op, 1'b1);
        if (mr) put(m, 1'b0);
        if (mr && m[7:6] != MOD_REGISTER && (m[7:6] != MOD_NO_DISP || dir))
            put(d[7:0], 1'b0);
        if (mr && (m[7:6] == MOD_DISP16 || dir)) put(d[15:8], 1'b0);
        BYTE_VALID = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge REF_CLK) begin
        if (OUT_VALID === 1'b1 && OUT_ACCEPT === 1'b1) begin
            if (q.size() == 0) chk("result count", 16'h0000, 16'h0001);
            else begin
                me = q.pop_front();
                chk("locked", me.lk, LOCKED);
                case (me.k)
                    2'h0: begin
                        chk("address", me.ea, EFFECTIVE_ADDRESS);
                        chk("segment", me.seg, SEGMENT);
                        chk("mem cycles", me.cyc, CYCLES);
                        chk("memory kind", 16'h0000, IS_REGISTER);
                        chk("mem not ctrl", 16'h0000, IS_CTRL_OP);
                        chk("mem locator", me.rm, RM_REG);
                        chk("mem reg field", me.rf, REG_FIELD);
                    end
                    2'h1: begin
                        chk("register kind", 16'h0001, IS_REGISTER);
                        chk("reg index", me.ri, REG_INDEX);
                        chk("reg code", me.rm, RM_REG);
                        chk("reg field", me.rf, REG_FIELD);
                        chk("reg not ctrl", 16'h0000, IS_CTRL_OP);
                    end
                    default: begin
                        chk("ctrl flag", 16'h0001, IS_CTRL_OP);
                        chk("ctrl cycles", me.cyc, CYCLES);
                    end
                endcase
            end
        end
    end
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        {RST, BYTE_VALID, BYTE_FIRST, HAS_MODRM, WORD_OP, STRING_DEST} = 6'h20;
        {BASE_REG, BASE_PTR_REG, SRC_INDEX_REG, DEST_INDEX_REG} = 64'h0;
        {BYTE_IN, lkn} = 9'h000;
        void'($urandom(35));
        repeat (3) @(posedge REF_CLK);
        #1 RST = 1'b0;
        for (int md = 0; md < 3; md++)
            for (int rm = 0; rm < 8; rm++)
                instr(8'h8b, {2'(md), 3'($urandom), 3'(rm)}, 1'b1,
                      16'($urandom), 1'($urandom), 1'b0, -1);
        $display("memory forms done");
        for (int r = 0; r < 16; r++)
            instr(8'h8b, {2'h3, 3'(r), 3'(r)}, 1'b1, 16'h0, r[3], 1'b0, -1);
        $display("register forms done");
        for (int s = 0; s < 4; s++)
            instr(8'h89, 8'h56, 1'b1, 16'($urandom), 1'b1, 1'b0, s);
        instr(8'haa, 8'h05, 1'b1, 16'h0000, 1'b0, 1'b1, 3);
        instr(8'haa, 8'h85, 1'b1, 16'h8001, 1'b1, 1'b1, -1);
        $display("segments done");
        foreach (ops[i]) instr(ops[i], 8'h00, 1'b0, 16'h0, 1'b0, 1'b0, -1);
        instr(OP_LOCK, 8'h00, 1'b0, 16'h0, 1'b0, 1'b0, -1);
        instr(8'h87, 8'h43, 1'b1, 16'h00ff, 1'b1, 1'b0, -1);
        instr(8'h87, 8'h06, 1'b1, 16'h1234, 1'b0, 1'b0, -1);
        idle();
        $display("control ops done");
        stop_test();
    end
endmodule

/* File: sim/operand_address_decoder_props.sv */
// port-level assertions for the operand address decoder
`timescale 1ns/1ps
module operand_address_decoder_props
    import opdec_pkg::*;
(
    input wire logic        REF_CLK,           // clock
    input wire logic        RST,               // async reset, high
    input wire logic        BYTE_VALID,        // byte offered
    input wire logic        BYTE_READY,        // byte taken
    input wire logic        BYTE_FIRST,        // opcode or prefix
    input wire logic        OUT_VALID,         // result offered
    input wire logic        OUT_ACCEPT,        // result taken
    input wire logic [15:0] EFFECTIVE_ADDRESS, // address out
    input wire logic [1:0]  SEGMENT,           // segment out
    input wire logic        IS_REGISTER,       // register operand
    input wire logic [3:0]  REG_INDEX,         // resolved register
    input wire logic        LOCKED,            // lock applies
    input wire logic        IS_CTRL_OP,        // control op
    input wire logic [7:0]  CYCLES             // cycles charged
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    a_result_holds: assert property (
        OUT_VALID && !OUT_ACCEPT |=> OUT_VALID && $stable(SEGMENT)
        && $stable(EFFECTIVE_ADDRESS) && $stable(CYCLES))
        else $error("result changed before it was taken");
    a_no_take_busy: assert property (
        OUT_VALID |-> !BYTE_READY) else $error("byte taken while holding");
    a_ctrl_two: assert property (
        OUT_VALID && IS_CTRL_OP |-> CYCLES == 8'h02)
        else $error("control op not two cycles");
    a_mem_cycles: assert property (
        OUT_VALID && !IS_REGISTER && !IS_CTRL_OP
        |-> CYCLES == 8'h04 || CYCLES == 8'h08)
        else $error("memory op cycle count wrong");
    a_calc_four: assert property (
        $rose(OUT_VALID) && !IS_REGISTER |-> $past(BYTE_READY, 5)
        && !$past(BYTE_READY, 4) && !$past(BYTE_READY, 1))
        else $error("address result not four cycles after last byte");
    a_ctrl_prompt: assert property (
        $rose(OUT_VALID) && IS_CTRL_OP |-> $past(BYTE_READY && BYTE_FIRST))
        else $error("control op result late");
    a_lock_once: assert property (
        OUT_VALID && OUT_ACCEPT && LOCKED && !IS_CTRL_OP |=> !LOCKED)
        else $error("lock outlived its instruction");
    a_byte_high: assert property (
        OUT_VALID && IS_REGISTER && REG_INDEX[3] |-> !REG_INDEX[2])
        else $error("bad high byte register index");
endmodule
bind operand_address_decoder operand_address_decoder_props props (
    .REF_CLK, .RST, .BYTE_VALID, .BYTE_READY, .BYTE_FIRST, .OUT_VALID,
    .OUT_ACCEPT, .EFFECTIVE_ADDRESS, .SEGMENT, .IS_REGISTER, .REG_INDEX,
    .LOCKED, .IS_CTRL_OP, .CYCLES);
